// file: logic/ctec_consts.vh
`ifndef CTEC_CONSTS_VH
`define CTEC_CONSTS_VH

// Clock rate and derived counts
`define CTEC_CLK_HZ          50000000
`define CTEC_CLK_PERIOD_NS   20
// Test pulse width
`define CTEC_TEST_PULSE_US   1
`define CTEC_TEST_PULSE_CYC  ((`CTEC_TEST_PULSE_US * 1000) / `CTEC_CLK_PERIOD_NS)
// Test pulse counter load: width in cycles less one
`define CTEC_TEST_PULSE_LOAD 6'h31
// Trigger lead ahead of cycle start
`define CTEC_TRIG_LEAD_NS    10
`define CTEC_TRIG_LEAD_CYC   (((`CTEC_TRIG_LEAD_NS + `CTEC_CLK_PERIOD_NS - 1) / `CTEC_CLK_PERIOD_NS) < 1 ? 1 : ((`CTEC_TRIG_LEAD_NS + `CTEC_CLK_PERIOD_NS - 1) / `CTEC_CLK_PERIOD_NS))
// Elapsed tick: 2^-16 s, fractional accumulator step = 2^32 * 2^16 / clk
`define CTEC_TICK_ACC_W      32
`define CTEC_TICK_STEP       32'd5629500
// Elapsed counter: 4096 s at 2^16 counts per second
`define CTEC_ELAPSED_FRAC_W  16
`define CTEC_ELAPSED_SEC_W   12
`define CTEC_ELAPSED_W       28
`define CTEC_ELAPSED_RST     28'h0000000
// Cycle index and operating modes
`define CTEC_INDEX_W         16
`define CTEC_MODE_W          2
`define CTEC_MODE_SINGLE     2'h0
`define CTEC_MODE_DUAL       2'h1
`define CTEC_MODE_TRIPLE     2'h2
`define CTEC_MODE_FOUR       2'h3
`define CTEC_LIMIT_SINGLE    16'hffff
`define CTEC_LIMIT_TWO_THREE 16'h7fff
`define CTEC_LIMIT_FOUR      16'h3fff

`endif

// file: logic/ctec_trig_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "ctec_consts.vh"

// =====================================================================
// One cycle-trigger channel
module ctec_trig_chan (
    input  wire                      sys_clk,
    input  wire                      resetn,
    input  wire                      seq_start,
    input  wire                      cycle_pre,
    input  wire [`CTEC_INDEX_W-1:0]  index,
    input  wire                      repeat_en,
    output reg                       pulse
);
    reg [`CTEC_INDEX_W-1:0] count;
    reg                     done;
    wire                    hit;

    // The pre-cycle strobe of cycle N+1... we count strobes; strobe k
    // announces cycle k, so the pulse lands ahead of that cycle start
    // Index zero must never fire, even when the count wraps
    assign hit = cycle_pre && !done && (index != 16'h0000) &&
                 (count + 16'h0001 == index);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 16'h0000;
            done  <= 1'b0;
            pulse <= 1'b0;
        end else begin
            pulse <= hit;
            if (seq_start) begin
                count <= 16'h0000;
                done  <= 1'b0;
            end else if (cycle_pre && !done) begin
                if (hit && repeat_en) begin
                    count <= 16'h0000;
                end else if (hit) begin
                    done <= 1'b1;
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: logic/ctec_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ctec_consts.vh"

// What this block does
// - Each of two channels pulses at its programmed DUT cycle index.
// - The pulse comes about 10 ns before the selected cycle starts.
// - With repeat set, a channel pulses every N cycles all sequence.
// - Without repeat, a channel pulses once per sequence.
// - A test command gives one immediate 1 us test pulse.
// - The elapsed counter advances once every 2^-16 seconds.
// - The elapsed counter spans 4096 seconds.
// - The station start input clears the counter and starts it.
// - The seconds output shows the count scaled to seconds, one clock late.
module ctec_top (
    input  wire                           sys_clk,
    input  wire                           resetn,
    input  wire                           seq_start,
    input  wire                           cycle_start,
    input  wire [`CTEC_MODE_W-1:0]        func_mode,
    input  wire [`CTEC_INDEX_W-1:0]       index_a,
    input  wire                           repeat_a,
    input  wire [`CTEC_INDEX_W-1:0]       index_b,
    input  wire                           repeat_b,
    input  wire                           test_cmd,
    input  wire                           start_button,
    output wire                           cycle_pulse_chan_a,
    output wire                           cycle_pulse_chan_b,
    output reg                            station_test_pulse,
    output wire                           index_a_bad,
    output wire                           index_b_bad,
    output reg  [`CTEC_ELAPSED_SEC_W-1:0] elapsed_sec,
    output reg  [`CTEC_ELAPSED_W-1:0]     elapsed_raw,
    output reg                            elapsed_run
);
    // =================================================================
    // Index limits per operating mode
    function [`CTEC_INDEX_W-1:0] mode_limit;
        input [`CTEC_MODE_W-1:0] mode;
        begin
            case (mode)
                `CTEC_MODE_SINGLE: mode_limit = `CTEC_LIMIT_SINGLE;
                `CTEC_MODE_DUAL:   mode_limit = `CTEC_LIMIT_TWO_THREE;
                `CTEC_MODE_TRIPLE: mode_limit = `CTEC_LIMIT_TWO_THREE;
                `CTEC_MODE_FOUR:   mode_limit = `CTEC_LIMIT_FOUR;
                // Unknown mode falls back to the tightest limit
                default:           mode_limit = `CTEC_LIMIT_FOUR;
            endcase
        end
    endfunction

    function index_out_of_range;
        input [`CTEC_INDEX_W-1:0] idx;
        input [`CTEC_MODE_W-1:0]  mode;
        begin
            index_out_of_range = (idx == 16'h0000) || (idx > mode_limit(mode));
        end
    endfunction

    // Flags only; the controller owns the range, so a bad index is
    // reported rather than corrected
    assign index_a_bad = index_out_of_range(index_a, func_mode);
    assign index_b_bad = index_out_of_range(index_b, func_mode);

    // =================================================================
    // Trigger channels
    // Indices are latched at sequence start; later changes wait for the
    // next sequence, matching how the controller loads them
    reg [`CTEC_INDEX_W-1:0] held_index_a;
    reg [`CTEC_INDEX_W-1:0] held_index_b;
    reg                     held_repeat_a;
    reg                     held_repeat_b;
    reg                     seq_go;
    reg [`CTEC_INDEX_W-1:0] next_held_index_a;
    reg [`CTEC_INDEX_W-1:0] next_held_index_b;
    reg                     next_held_repeat_a;
    reg                     next_held_repeat_b;

    always @* begin
        next_held_index_a  = held_index_a;
        next_held_index_b  = held_index_b;
        next_held_repeat_a = held_repeat_a;
        next_held_repeat_b = held_repeat_b;
        if (seq_start) begin
            next_held_index_a  = index_a;
            next_held_index_b  = index_b;
            next_held_repeat_a = repeat_a;
            next_held_repeat_b = repeat_b;
        end
    end

    // The channels restart one clock after the latch, so both see the
    // new index on their first counted strobe
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            held_index_a  <= 16'h0000;
            held_index_b  <= 16'h0000;
            held_repeat_a <= 1'b0;
            held_repeat_b <= 1'b0;
            seq_go        <= 1'b0;
        end else begin
            held_index_a  <= next_held_index_a;
            held_index_b  <= next_held_index_b;
            held_repeat_a <= next_held_repeat_a;
            held_repeat_b <= next_held_repeat_b;
            seq_go        <= seq_start;
        end
    end

    // cycle_start marks a point one lead-time ahead of each DUT cycle
    // The pulse leaves one clock after the strobe; that clock is part
    // of the lead, so the caller places the strobe with it in mind
    ctec_trig_chan u_chan_a (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .seq_start (seq_go),
        .cycle_pre (cycle_start),
        .index     (held_index_a),
        .repeat_en (held_repeat_a),
        .pulse     (cycle_pulse_chan_a)
    );

    ctec_trig_chan u_chan_b (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .seq_start (seq_go),
        .cycle_pre (cycle_start),
        .index     (held_index_b),
        .repeat_en (held_repeat_b),
        .pulse     (cycle_pulse_chan_b)
    );

    // =================================================================
    // Test pulse
    reg [5:0] test_count;
    reg [5:0] next_test_count;
    reg       next_station_test_pulse;

    // A new command restarts the full width, so a retrigger stretches
    // the pulse rather than notching it
    always @* begin
        next_test_count         = test_count;
        next_station_test_pulse = station_test_pulse;
        if (test_cmd) begin
            next_test_count         = `CTEC_TEST_PULSE_LOAD;
            next_station_test_pulse = 1'b1;
        end else if (test_count != 6'h00) begin
            next_test_count = test_count - 6'h01;
        end else begin
            next_station_test_pulse = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            test_count         <= 6'h00;
            station_test_pulse <= 1'b0;
        end else begin
            test_count         <= next_test_count;
            station_test_pulse <= next_station_test_pulse;
        end
    end

    // =================================================================
    // Elapsed-time counter
    // Fractional accumulator: carry out gives one enable every 2^-16 s on
    // average; single ticks jitter by one clock, which is far below 15 us
    reg  [`CTEC_TICK_ACC_W-1:0] tick_acc;
    reg                         tick;
    wire [`CTEC_TICK_ACC_W:0]   tick_sum;
    reg  [`CTEC_TICK_ACC_W-1:0] next_tick_acc;
    reg                         next_tick;
    reg  [`CTEC_ELAPSED_W-1:0]  next_elapsed_raw;
    reg                         next_elapsed_run;

    assign tick_sum = {1'b0, tick_acc} + {1'b0, `CTEC_TICK_STEP};

    // Start wins over a tick in the same clock, so a restart is clean
    always @* begin
        next_tick_acc    = tick_acc;
        next_tick        = tick;
        next_elapsed_raw = elapsed_raw;
        next_elapsed_run = elapsed_run;
        if (start_button) begin
            next_tick_acc    = 32'h00000000;
            next_tick        = 1'b0;
            next_elapsed_raw = `CTEC_ELAPSED_RST;
            next_elapsed_run = 1'b1;
        end else if (elapsed_run) begin
            next_tick_acc = tick_sum[`CTEC_TICK_ACC_W-1:0];
            next_tick     = tick_sum[`CTEC_TICK_ACC_W];
            if (tick) begin
                // 28 bits of 2^-16 s span 4096 s and wrap to zero
                next_elapsed_raw = elapsed_raw + 28'h0000001;
            end
        end
    end

    // Seconds lag the raw count by one clock
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_acc    <= 32'h00000000;
            tick        <= 1'b0;
            elapsed_raw <= `CTEC_ELAPSED_RST;
            elapsed_run <= 1'b0;
            elapsed_sec <= 12'h000;
        end else begin
            tick_acc    <= next_tick_acc;
            tick        <= next_tick;
            elapsed_raw <= next_elapsed_raw;
            elapsed_run <= next_elapsed_run;
            elapsed_sec <=
                elapsed_raw[`CTEC_ELAPSED_W-1:`CTEC_ELAPSED_FRAC_W];
        end
    end
endmodule

`default_nettype wire

// file: testbench/ctec_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctec_consts.vh"
// ==========================
// Port checker
module ctec_top_sva (
    input wire logic                         sys_clk,
    input wire logic                         resetn,
    input wire logic                         cycle_start,
    input wire logic [1:0]                   func_mode,
    input wire logic [15:0]                  index_a,
    input wire logic                         test_cmd,
    input wire logic                         start_button,
    input wire logic                         cycle_pulse_chan_a,
    input wire logic                         cycle_pulse_chan_b,
    input wire logic                         station_test_pulse,
    input wire logic                         index_a_bad,
    input wire logic [11:0]                  elapsed_sec,
    input wire logic [27:0]                  elapsed_raw,
    input wire logic                         elapsed_run
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [5:0]  tp_cnt;
    logic [15:0] lim;
    assign lim = func_mode == 2'h0 ? 16'hffff :
                 func_mode == 2'h3 ? 16'h3fff : 16'h7fff;
    // Cycles since last test command; parks at 51 so it cannot wrap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            tp_cnt <= 6'h00;
        else if (test_cmd)
            tp_cnt <= 6'h01;
        else if (tp_cnt != 6'h00 && tp_cnt != 6'h33)
            tp_cnt <= tp_cnt + 6'h01;
    end
    a_test_width: assert property (
        station_test_pulse == (tp_cnt != 6'h00 && tp_cnt != 6'h33))
        else $error("test pulse width wrong");
    a_chan_a_cause: assert property (
        cycle_pulse_chan_a |-> $past(cycle_start))
        else $error("chan a pulse without cycle");
    a_chan_b_cause: assert property (
        cycle_pulse_chan_b |-> $past(cycle_start))
        else $error("chan b pulse without cycle");
    a_start_clears: assert property (
        start_button |=> elapsed_raw == 28'h0 && elapsed_run)
        else $error("start did not clear counter");
    a_raw_step: assert property (
        elapsed_run && !start_button |=> elapsed_raw == $past(elapsed_raw)
        || elapsed_raw == $past(elapsed_raw) + 28'h1)
        else $error("counter stepped wrongly");
    a_raw_alive: assert property (
        elapsed_run |-> ##[1:800] $changed(elapsed_raw))
        else $error("counter stalled");
    a_sec_scaled: assert property (
        elapsed_sec == $past(elapsed_raw[27:16]))
        else $error("seconds not scaled from count");
    a_bad_flag: assert property (
        index_a_bad == (index_a == 16'h0 || index_a > lim))
        else $error("index range flag wrong");
    c_chan_a: cover property (cycle_pulse_chan_a);
    c_chan_b: cover property (cycle_pulse_chan_b);
    c_test: cover property ($fell(station_test_pulse));
endmodule
`default_nettype wire

// file: testbench/ctec_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Controller: one sequence of cycle points per go
module ctec_ctrl_model (
    input wire logic        sys_clk,
    input wire logic        go,
    input wire logic [15:0] gap,
    input wire logic [15:0] ncyc,
    output logic            seq_start,
    output logic            cycle_start,
    output logic            busy
);
    initial {seq_start, cycle_start, busy} = 3'h0;
    always @(posedge go) begin
        busy = 1'b1;
        @(negedge sys_clk) seq_start = 1'b1;
        @(negedge sys_clk) seq_start = 1'b0;
        for (int i = 1; i <= ncyc * gap; i++)
            @(negedge sys_clk) cycle_start = (i % gap == 0);
        @(negedge sys_clk) cycle_start = 1'b0;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// file: testbench/ctec_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Bench top
module ctec_top_tb;
    logic        sys_clk, resetn, seq_start, cycle_start, repeat_a, repeat_b;
    logic        test_cmd, start_button, go, busy, pa, pb, tp, bad_a, bad_b;
    logic        run;
    logic [1:0]  func_mode;
    logic [15:0] index_a, index_b, gap, ncyc, cs, last_a, last_b;
    logic [11:0] sec;
    logic [27:0] raw;
    int          bad_count, checks_done, na, nb, n;
    ctec_top u_dut (.sys_clk, .resetn, .seq_start, .cycle_start, .func_mode,
        .index_a, .repeat_a, .index_b, .repeat_b, .test_cmd, .start_button,
        .cycle_pulse_chan_a(pa), .cycle_pulse_chan_b(pb),
        .station_test_pulse(tp), .index_a_bad(bad_a), .index_b_bad(bad_b),
        .elapsed_sec(sec), .elapsed_raw(raw), .elapsed_run(run));
    ctec_ctrl_model u_ctrl (.sys_clk, .go, .gap, .ncyc, .seq_start,
        .cycle_start, .busy);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cs <= seq_start ? 16'h0 : cs + {15'h0, cycle_start};
        if (pa) begin
            na++;
            last_a = cs;
        end
        if (pb) begin
            nb++;
            last_b = cs;
        end
    end
    task check(input string what, input logic [27:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task run_seq(input [15:0] ia, input ra, input [15:0] ib, input rb,
                 input [15:0] g, input [15:0] c);
        @(negedge sys_clk) {index_a, repeat_a, index_b, repeat_b} = {ia, ra, ib, rb};
        {gap, ncyc, na, nb, go} = {g, c, 64'h0, 1'b1};
        @(negedge sys_clk) go = 1'b0;
        for (n = 0; n < 9000 && busy; n++)
            @(negedge sys_clk);
        check("seq done", 0, busy);
        repeat (2) @(negedge sys_clk);
    endtask
    task t_chan_mix;
        func_mode = 2'h0;
        run_seq(16'd10, 1'b1, 16'd15, 1'b0, 16'd1, 16'd200);
        check("count a", 20, na);
        check("last a", 200, last_a);
        check("count b", 1, nb);
        check("last b", 15, last_b);
    endtask
    task t_chan_edge;
        func_mode = 2'h3;
        run_seq(16'd0, 1'b1, 16'd1, 1'b1, 16'd3, 16'd6);
        check("zero index", 0, na);
        check("every cycle", 6, nb);
        run_seq(16'd3, 1'b0, 16'd4, 1'b0, 16'd2, 16'd9);
        check("rearm a", 1, na);
        check("rearm last a", 3, last_a);
        check("rearm b", 1, nb);
        check("rearm last b", 4, last_b);
    endtask
    task t_bad_flags;
        logic [15:0] lim[4];
        lim = '{16'hffff, 16'h7fff, 16'h7fff, 16'h3fff};
        for (int m = 0; m < 4; m++) begin
            @(negedge sys_clk) func_mode = m[1:0];
            {index_a, index_b} = {lim[m], lim[m] + 16'h1};
            #1 check("at limit", 0, bad_a);
            check("over limit", 1, bad_b);
        end
    endtask
    task t_test_pulse;
        @(negedge sys_clk) test_cmd = 1'b1;
        @(negedge sys_clk) test_cmd = 1'b0;
        check("test rise", 1, tp);
        for (n = 1; n < 60; n++)
            @(negedge sys_clk) if (!tp) break;
        check("test width", 50, n);
    endtask
    task t_elapsed;
        check("idle run", 0, run);
        check("idle count", 0, raw);
        @(negedge sys_clk) start_button = 1'b1;
        @(negedge sys_clk) start_button = 1'b0;
        check("started", 1, run);
        check("cleared", 0, raw);
        repeat (7640) @(negedge sys_clk);
        check("ticks", 1, raw >= 10 && raw <= 11);
        check("seconds", 0, sec);
        check("span", 28, $bits(u_dut.elapsed_raw));
        @(negedge sys_clk) start_button = 1'b1;
        @(negedge sys_clk) start_button = 1'b0;
        check("restart", 0, raw);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        {resetn, repeat_a, repeat_b, test_cmd, start_button, go} = 6'h0;
        {func_mode, index_a, index_b, bad_count, checks_done} = '0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk) resetn = 1'b1;
        t_elapsed;
        t_chan_mix;
        t_chan_edge;
        t_bad_flags;
        t_test_pulse;
        tally_and_finish;
    end
endmodule
bind ctec_top ctec_top_sva u_sva (.sys_clk, .resetn, .cycle_start,
    .func_mode, .index_a, .test_cmd, .start_button, .cycle_pulse_chan_a,
    .cycle_pulse_chan_b, .station_test_pulse, .index_a_bad, .elapsed_sec,
    .elapsed_raw, .elapsed_run);
`default_nettype wire
